// ### rtl/radio_consts.svh
// Constants of the radio power and modem control link.
// Assumes a 125 MHz system clock shared by both ends.
`ifndef RADIO_CONSTS_SVH
`define RADIO_CONSTS_SVH

// ==========================================================
// Register offsets on the link
`define A_PWR        8'h00
`define A_MODCFG     8'h01
`define A_FRAME      8'h02
`define A_PRELEN     8'h03
`define A_PAT0       8'h04
`define A_PAT3       8'h07
`define A_BITDIV     8'h08
`define A_GAIN       8'h09
`define A_RSSI       8'h0a
`define A_OFS0       8'h0b
`define A_OFS3       8'h0e
`define A_FIFO       8'h0f
`define A_STAT       8'h10

// ==========================================================
// Field positions
`define MC_MOD_LSB   0
`define MC_SHP_LSB   2
`define MC_AMP_BIT   4
`define FR_PRE_BIT   0
`define ST_EMPTY     0
`define ST_FULL      1
`define ST_ALIGN     2
`define ST_OVF       3
`define ST_PEND      4
`define ST_GAINOK    5

// ==========================================================
// Reset values and limits
`define RST_MODCFG   5'h10
`define RST_PRELEN   6'h08
`define PRELEN_MIN   6'h04
`define PRELEN_MAX   6'h20
`define RST_PAT      32'h000000aa
`define RST_BITDIV   8'h0f
`define RD_NONE      8'h00
`define INIT_CYC     8'h10

// Frequency steps in deviation units, 3-bit two's complement
`define FS_M3        3'h5
`define FS_M1        3'h7
`define FS_P1        3'h1
`define FS_P3        3'h3
`define FS_ZERO      3'h0

// ==========================================================
// Timing: crystal settling in standby
`define SETTLE_US    3000
`define CLK_MHZ      125
`define FIFO_DEPTH   8
`define BYTE_W       8

`endif

// ### rtl/radio_pkg.sv
// Types shared by both ends of the radio control link.
// Assumes the constants header is included by the users.
package radio_pkg;

  typedef enum logic [3:0] {
    PS_CORE_OFF    = 4'h0,
    PS_TOTAL_OFF   = 4'h1,
    PS_STANDBY     = 4'h5,
    PS_FIFO        = 4'h6,
    PS_RX_SETTLE   = 4'h8,
    PS_RX_ACTIVE   = 4'h9,
    PS_WAKE_LISTEN = 4'hb,
    PS_TX_SETTLE   = 4'hc,
    PS_TX_ACTIVE   = 4'hd
  } radio_power_state_t;

  typedef enum logic [1:0] {
    MOD_ASK  = 2'h0,
    MOD_FSK  = 2'h1,
    MOD_PSK  = 2'h2,
    MOD_FSK4 = 2'h3
  } mod_t;

  typedef enum logic [1:0] {
    SH_HARD     = 2'h0,
    SH_GAUSS_03 = 2'h1,
    SH_GAUSS_05 = 2'h2,
    SH_RSVD     = 2'h3
  } shape_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_REQ  = 4'h2,
    H_HOLD = 4'h4,
    H_WAKE = 4'h8
  } host_state_t;

endpackage : radio_pkg

// ### rtl/radio_link_if.sv
// Link between host controller and transceiver control block.
// Plain single-clock signals; both ends sample on i_clk.
`timescale 1ns/100ps
interface radio_link_if;
  logic       sel_n;
  logic       req;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;
  logic       miso;

  modport device (input sel_n, req, we, addr, wdata,
                  output rdata, ack, miso);
  modport host   (output sel_n, req, we, addr, wdata,
                  input rdata, ack, miso);
endinterface : radio_link_if

// ### rtl/radio_device.sv
// Transceiver control end: power state, raw framing, modulator map.
// Assumes the host keeps req high until ack and honours miso wake.
//
// Notes on behaviour
// - Raw mode: plain serialize and byte deserialize.
// - Preamble mode: drop bits until pattern, align.
// - Preamble length programmable from 4 to 32.
// - Gain loop value readable once synth programmed.
// - Post-filter signal strength readable, 1 dB steps.
// - ASK zero off one on; PSK one flips.
// - Binary FSK zero minus, one plus deviation.
// - Four-level FSK dibit map, always hard shaping.
// - Binary shaping hard or Gaussian 0.3/0.5.
// - Amplitude shaping offered; host keeps it enabled.
// - Carrier offset readable as 32-bit fraction value.
// - Power state codes decode nine defined states.
// - Core off keeps registers, loses FIFO, waits empty.
// - Total off loses registers; wake by select, miso.
// - Standby: oscillator on, FIFO lost, waits empty.
// - FIFO state keeps FIFO and allows access.
// - Rx settle runs synth; rx active adds receiver.
// - Wake listen is core off plus low oscillator.
// - Host enters transmit active only after settling.
// - Host allows crystal settling in standby.
`timescale 1ns/100ps
`include "radio_consts.svh"

// ==========================================================
// Byte FIFO between link and modem
module radio_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_flush,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  logic         push;
  logic         pop;

  assign o_in_ready  = (wp_r - rp_r) != (AW+1)'(D);
  assign o_out_valid = wp_r != rp_r;
  assign o_out_data  = mem[rp_r[AW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = i_out_ready && o_out_valid;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_flush) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop)  rp_r <= rp_r + 1'b1;
    end
  end
endmodule : radio_fifo

// ==========================================================
module radio_device (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Link to host
  radio_link_if.device     link,
  // Analog and demodulator status
  input  wire logic [7:0]  i_gain_loop,
  input  wire logic [7:0]  i_rssi,
  input  wire logic [31:0] i_carrier_offset,
  input  wire logic        i_synth_prog,
  input  wire logic        i_rx_bit,
  input  wire logic        i_rx_bit_valid,
  // Power domain enables
  output logic             o_osc_en,
  output logic             o_ref_en,
  output logic             o_synth_en,
  output logic             o_synth_tx,
  output logic             o_rx_en,
  output logic             o_tx_en,
  output logic             o_lposc_en,
  // Modulator drive
  output logic             o_pa_on,
  output logic [2:0]       o_freq_step,
  output logic             o_phase,
  output logic             o_amp_shape_en,
  output radio_pkg::shape_t o_freq_shape,
  output logic             o_sym_strobe,
  output logic             o_rx_aligned
);
  import radio_pkg::*;

  radio_power_state_t pwr_r, pend_st_r;
  logic        pend_r, asleep_r, waking_r, ovf_r;
  logic [7:0]  init_r, bitdiv_r, div_r, sh_r, rxb_r, rdv;
  logic [4:0]  modcfg_r;
  logic        pre_mode_r;
  logic [5:0]  prelen_r;
  logic [31:0] pat_r, win_r, win_nxt, mask;
  logic [3:0]  sh_cnt_r;
  logic [2:0]  rx_cnt_r;
  logic        rx_push_r;
  logic        cfg_clr, take, wr_stall, is_fifo, fifo_open, rx_dir;
  logic        host_push, host_pop, ser_load, tick, tx_act, rx_act;
  logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [7:0]  f_in_data, f_out_data;
  logic        legal, f_empty;
  mod_t        mod;

  function automatic logic legal_code(input logic [3:0] c);
    unique case (c)
      PS_CORE_OFF, PS_TOTAL_OFF, PS_STANDBY, PS_FIFO, PS_RX_SETTLE,
      PS_RX_ACTIVE, PS_WAKE_LISTEN, PS_TX_SETTLE,
      PS_TX_ACTIVE: legal_code = 1'b1;
      default:      legal_code = 1'b0;
    endcase
  endfunction : legal_code

  // ==========================================================
  // Access decode
  assign mod       = mod_t'(modcfg_r[`MC_MOD_LSB +: 2]);
  assign tx_act    = pwr_r == PS_TX_ACTIVE;
  assign rx_act    = pwr_r == PS_RX_ACTIVE;
  assign fifo_open = pwr_r inside {PS_FIFO, PS_RX_SETTLE, PS_RX_ACTIVE,
                                   PS_TX_SETTLE, PS_TX_ACTIVE};
  assign rx_dir    = pwr_r inside {PS_RX_SETTLE, PS_RX_ACTIVE};
  assign is_fifo   = link.addr == `A_FIFO;
  assign f_empty   = !f_out_valid;
  assign wr_stall  = link.we && is_fifo && fifo_open && !rx_dir &&
                     !f_in_ready;
  assign take      = link.req && !link.ack && !asleep_r && !wr_stall;
  assign host_push = take && link.we && is_fifo && fifo_open && !rx_dir;
  assign host_pop  = take && !link.we && is_fifo && fifo_open &&
                     !tx_act && f_out_valid;
  assign legal     = legal_code(link.wdata[3:0]);
  assign cfg_clr   = !i_rst_n || asleep_r;

  // ==========================================================
  // Power state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pwr_r     <= PS_CORE_OFF;
      pend_r    <= 1'b0;
      pend_st_r <= PS_CORE_OFF;
    end else if (asleep_r) begin
      pend_r <= 1'b0;
      if (waking_r && init_r == 8'h00) pwr_r <= PS_CORE_OFF;
    end else if (take && link.we && link.addr == `A_PWR && legal) begin
      if (link.wdata[3:0] inside {PS_CORE_OFF, PS_STANDBY,
                                  PS_WAKE_LISTEN} && !f_empty) begin
        pend_r    <= 1'b1;
        pend_st_r <= radio_power_state_t'(link.wdata[3:0]);
      end else begin
        pend_r <= 1'b0;
        pwr_r  <= radio_power_state_t'(link.wdata[3:0]);
      end
    end else if (pend_r && f_empty) begin
      pend_r <= 1'b0;
      pwr_r  <= pend_st_r;
    end
  end

  // Deep sleep and wake handshake
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      asleep_r <= 1'b0;
      waking_r <= 1'b0;
      init_r   <= 8'h00;
    end else if (!asleep_r) begin
      asleep_r <= pwr_r == PS_TOTAL_OFF;
      waking_r <= 1'b0;
    end else if (!waking_r) begin
      waking_r <= !link.sel_n;
      init_r   <= `INIT_CYC;
    end else if (init_r == 8'h00) begin
      asleep_r <= 1'b0;
      waking_r <= 1'b0;
    end else begin
      init_r <= init_r - 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      link.miso <= 1'b1;
    end else begin
      link.miso <= !asleep_r && pwr_r != PS_TOTAL_OFF;
    end
  end

  always_ff @(posedge i_clk) begin
    o_osc_en   <= pwr_r inside {PS_STANDBY, PS_RX_SETTLE, PS_RX_ACTIVE,
                                PS_TX_SETTLE, PS_TX_ACTIVE};
    o_ref_en   <= pwr_r inside {PS_STANDBY, PS_FIFO, PS_RX_SETTLE,
                                PS_RX_ACTIVE, PS_TX_SETTLE,
                                PS_TX_ACTIVE};
    o_synth_en <= pwr_r inside {PS_RX_SETTLE, PS_RX_ACTIVE,
                                PS_TX_SETTLE, PS_TX_ACTIVE};
    o_synth_tx <= pwr_r inside {PS_TX_SETTLE, PS_TX_ACTIVE};
    o_rx_en    <= rx_act;
    o_tx_en    <= tx_act;
    o_lposc_en <= pwr_r == PS_WAKE_LISTEN;
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (cfg_clr) begin
      modcfg_r   <= `RST_MODCFG;
      pre_mode_r <= 1'b0;
      prelen_r   <= `RST_PRELEN;
      pat_r      <= `RST_PAT;
      bitdiv_r   <= `RST_BITDIV;
    end else if (take && link.we) begin
      unique case (link.addr)
        `A_MODCFG: modcfg_r   <= link.wdata[4:0];
        `A_FRAME:  pre_mode_r <= link.wdata[`FR_PRE_BIT];
        `A_PRELEN: begin
          if (link.wdata < 8'(`PRELEN_MIN))       prelen_r <= `PRELEN_MIN;
          else if (link.wdata > 8'(`PRELEN_MAX)) prelen_r <= `PRELEN_MAX;
          else prelen_r <= link.wdata[5:0];
        end
        `A_BITDIV: bitdiv_r <= link.wdata;
        default: begin
          if (link.addr >= `A_PAT0 && link.addr <= `A_PAT3) begin
            pat_r[8*link.addr[1:0] +: 8] <= link.wdata;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Register reads and link answer
  always_comb begin
    rdv = `RD_NONE;
    unique case (link.addr)
      `A_PWR:    rdv = {4'h0, pend_r ? pend_st_r : pwr_r};
      `A_MODCFG: rdv = {3'h0, modcfg_r};
      `A_FRAME:  rdv = {7'h00, pre_mode_r};
      `A_PRELEN: rdv = {2'h0, prelen_r};
      `A_BITDIV: rdv = bitdiv_r;
      `A_GAIN:   rdv = i_synth_prog ? i_gain_loop : `RD_NONE;
      `A_RSSI:   rdv = i_rssi;
      `A_FIFO:   rdv = host_pop ? f_out_data : `RD_NONE;
      `A_STAT:   rdv = {2'h0, i_synth_prog, pend_r, ovf_r, o_rx_aligned,
                        !f_in_ready, f_empty};
      default: begin
        if (link.addr >= `A_PAT0 && link.addr <= `A_PAT3) begin
          rdv = pat_r[8*link.addr[1:0] +: 8];
        end else if (link.addr >= `A_OFS0 && link.addr <= `A_OFS3) begin
          rdv = i_carrier_offset[8*(link.addr-`A_OFS0) +: 8];
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      link.ack   <= 1'b0;
      link.rdata <= 8'h00;
    end else begin
      link.ack <= take;
      if (take && !link.we) link.rdata <= rdv;
    end
  end

  // ==========================================================
  // FIFO, direction switched by power state
  assign f_in_valid  = host_push || rx_push_r;
  assign f_in_data   = host_push ? link.wdata : rxb_r;
  assign f_out_ready = host_pop || ser_load;

  radio_fifo #(.W(`BYTE_W), .D(`FIFO_DEPTH)) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_flush     (!fifo_open),
    .i_in_valid  (f_in_valid),
    .i_in_data   (f_in_data),
    .o_in_ready  (f_in_ready),
    .o_out_valid (f_out_valid),
    .o_out_data  (f_out_data),
    .i_out_ready (f_out_ready)
  );

  // ==========================================================
  // Transmit: bit divider, serializer and symbol map
  assign tick     = tx_act && div_r == 8'h00;
  assign ser_load = tx_act && sh_cnt_r == 4'h0 && f_out_valid;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !tx_act) div_r <= 8'h00;
    else div_r <= (div_r == 8'h00) ? bitdiv_r : div_r - 8'h01;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !tx_act) begin
      sh_cnt_r <= 4'h0;
      sh_r     <= 8'h00;
    end else if (ser_load) begin
      sh_r     <= f_out_data;
      sh_cnt_r <= 4'h8;
    end else if (tick && sh_cnt_r != 4'h0) begin
      if (mod == MOD_FSK4) begin
        sh_r     <= {sh_r[5:0], 2'h0};
        sh_cnt_r <= (sh_cnt_r < 4'h2) ? 4'h0 : sh_cnt_r - 4'h2;
      end else begin
        sh_r     <= {sh_r[6:0], 1'h0};
        sh_cnt_r <= sh_cnt_r - 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !tx_act) begin
      o_pa_on      <= 1'b0;
      o_freq_step  <= `FS_ZERO;
      o_phase      <= 1'b0;
      o_sym_strobe <= 1'b0;
    end else begin
      o_sym_strobe <= tick && sh_cnt_r != 4'h0;
      if (tick && sh_cnt_r != 4'h0) begin
        unique case (mod)
          MOD_ASK: o_pa_on <= sh_r[7];
          MOD_FSK: begin
            o_pa_on     <= 1'b1;
            o_freq_step <= sh_r[7] ? `FS_P1 : `FS_M1;
          end
          MOD_PSK: begin
            o_pa_on <= 1'b1;
            o_phase <= o_phase ^ sh_r[7];
          end
          MOD_FSK4: begin
            o_pa_on <= 1'b1;
            unique case (sh_r[7:6])
              2'h0: o_freq_step <= `FS_M3;
              2'h1: o_freq_step <= `FS_M1;
              2'h3: o_freq_step <= `FS_P1;
              2'h2: o_freq_step <= `FS_P3;
            endcase
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    o_amp_shape_en <= modcfg_r[`MC_AMP_BIT];
    o_freq_shape   <= (mod == MOD_FSK4) ? SH_HARD
                    : shape_t'(modcfg_r[`MC_SHP_LSB +: 2]);
  end

  // ==========================================================
  // Receive: preamble hunt and byte deserializer
  assign win_nxt = {win_r[30:0], i_rx_bit};
  assign mask    = 32'hffffffff >> (6'h20 - prelen_r);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !rx_act) begin
      win_r        <= 32'h0;
      o_rx_aligned <= 1'b0;
      rx_cnt_r     <= 3'h0;
      rx_push_r    <= 1'b0;
      rxb_r        <= 8'h00;
    end else begin
      rx_push_r <= 1'b0;
      if (i_rx_bit_valid) begin
        win_r <= win_nxt;
        if (!pre_mode_r || o_rx_aligned) begin
          o_rx_aligned <= 1'b1;
          rxb_r        <= {rxb_r[6:0], i_rx_bit};
          rx_cnt_r     <= rx_cnt_r + 3'h1;
          rx_push_r    <= rx_cnt_r == 3'h7;
        end else if (((win_nxt ^ pat_r) & mask) == 32'h0) begin
          o_rx_aligned <= 1'b1;
          rx_cnt_r     <= 3'h0;
        end
      end
    end
  end

  // Overflow: set wins over clear-on-read
  always_ff @(posedge i_clk) begin
    if (cfg_clr) ovf_r <= 1'b0;
    else if (rx_push_r && !f_in_ready) ovf_r <= 1'b1;
    else if (take && !link.we && link.addr == `A_STAT) ovf_r <= 1'b0;
  end
endmodule : radio_device

// ### rtl/radio_host.sv
// Host end: issues register accesses, wakes the device from total off.
// Assumes the device answers each request with a one-cycle ack.
`timescale 1ns/100ps
`include "radio_consts.svh"

module radio_host #(
  parameter int SETTLE_CYC = `SETTLE_US * `CLK_MHZ
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Link to device
  radio_link_if.host      link,
  // Command port
  input  wire logic       i_cmd_valid,
  input  wire logic       i_cmd_we,
  input  wire logic [7:0] i_cmd_addr,
  input  wire logic [7:0] i_cmd_wdata,
  output logic            o_cmd_ready,
  output logic            o_rsp_valid,
  output logic [7:0]      o_rsp_data,
  // Wake request
  input  wire logic       i_wake,
  output logic            o_awake
);
  import radio_pkg::*;

  host_state_t st_r;
  logic [31:0] stl_r;
  logic        stl_run_r;
  logic        settled, is_pwr_wr;

  assign settled   = stl_run_r && stl_r >= 32'(SETTLE_CYC);
  assign is_pwr_wr = i_cmd_we && i_cmd_addr == `A_PWR;

  // ==========================================================
  // Settling timer since last standby or tx settle request
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stl_r     <= 32'h0;
      stl_run_r <= 1'b0;
    end else if (st_r == H_IDLE && i_cmd_valid && !i_wake && is_pwr_wr &&
                 i_cmd_wdata[3:0] != PS_TX_ACTIVE) begin
      stl_r     <= 32'h0;
      stl_run_r <= i_cmd_wdata[3:0] inside {PS_STANDBY,
                                            PS_TX_SETTLE};
    end else if (stl_run_r && !settled) begin
      stl_r <= stl_r + 32'h1;
    end
  end

  // ==========================================================
  // Request sequencer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r        <= H_IDLE;
      link.sel_n  <= 1'b1;
      link.req    <= 1'b0;
      link.we     <= 1'b0;
      link.addr   <= 8'h00;
      link.wdata  <= 8'h00;
      o_cmd_ready <= 1'b1;
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= 8'h00;
      o_awake     <= 1'b0;
    end else begin
      o_rsp_valid <= 1'b0;
      o_awake     <= 1'b0;
      unique case (st_r)
        H_IDLE: begin
          if (i_wake) begin
            link.sel_n  <= 1'b0;
            o_cmd_ready <= 1'b0;
            st_r        <= H_WAKE;
          end else if (i_cmd_valid) begin
            o_cmd_ready <= 1'b0;
            link.we     <= i_cmd_we;
            link.addr   <= i_cmd_addr;
            link.wdata  <= i_cmd_wdata;
            if (i_cmd_we && i_cmd_addr == `A_MODCFG) begin
              link.wdata[`MC_AMP_BIT] <= 1'b1;
            end
            if (is_pwr_wr && i_cmd_wdata[3:0] == PS_TX_ACTIVE &&
                !settled) begin
              st_r <= H_HOLD;
            end else begin
              link.req <= 1'b1;
              st_r     <= H_REQ;
            end
          end
        end
        H_HOLD: begin
          if (settled) begin
            link.req <= 1'b1;
            st_r     <= H_REQ;
          end
        end
        H_REQ: begin
          if (link.ack) begin
            link.req    <= 1'b0;
            o_rsp_valid <= 1'b1;
            o_rsp_data  <= link.we ? 8'h00 : link.rdata;
            o_cmd_ready <= 1'b1;
            st_r        <= H_IDLE;
          end
        end
        H_WAKE: begin
          if (link.miso) begin
            link.sel_n  <= 1'b1;
            o_awake     <= 1'b1;
            o_cmd_ready <= 1'b1;
            st_r        <= H_IDLE;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
endmodule : radio_host

// ### verif/radio_link_assertions.sv
// Link checker: handshake, unmapped reads, sleep and wake timing.
// Assumes one clock i_clk and a synchronous active-low i_rst_n.
`timescale 1ns/100ps
module radio_link_checker (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  // Link signals
  input wire logic       sel_n,
  input wire logic       req,
  input wire logic       we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack,
  input wire logic       miso
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ====
  // Handshake
  property p_ack_pulse; ack |=> !ack && !req; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack not a single cycle");
  property p_ack_cause; ack |-> req && $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_req_hold; req && !ack |=> req && $stable(addr); endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before ack");
  property p_unmapped; ack && !we && addr > 8'h10 |-> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  // ====
  // Sleep and wake
  property p_sleep;
    ack && we && addr == 8'h00 && wdata == 8'h01 |-> ##[0:2] !miso;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("miso high after sleep");
  property p_mute; !miso && $past(!miso) |-> !ack; endproperty
  a_mute: assert property (p_mute)
    else $error("ack while asleep");
  property p_wake; $fell(sel_n) && !miso |-> !miso[*8] ##[8:14] miso;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake time wrong");
  property p_sel_back; $rose(miso) |-> ##[1:3] sel_n; endproperty
  a_sel_back: assert property (p_sel_back)
    else $error("select not released");
endmodule : radio_link_checker

// ### verif/test_radio_power_modem_control.sv
// Bench: host and device joined by the link, driven by host commands.
// Assumes a 125 MHz clock and a short crystal settling count.
`timescale 1ns/100ps
module test_radio_power_modem_control;
  logic       i_clk, i_rst_n, cmd_valid, cmd_we, rsp_valid, ready;
  logic       wake, synth_prog, awake, osc, rf, syn, rx, lpo, pa;
  logic       rbit, rval, txe, amp;
  logic [1:0] fshp;
  logic [2:0] fstep;
  logic [7:0] cmd_addr, cmd_wdata, rsp_data;
  int         bad_count, checked, n;

  radio_link_if lk ();
  radio_host #(.SETTLE_CYC(20)) u_radio_host (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .link(lk), .i_cmd_valid(cmd_valid),
    .i_cmd_we(cmd_we), .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata),
    .o_cmd_ready(ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .i_wake(wake), .o_awake(awake));
  radio_device u_radio_device (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .link(lk), .i_gain_loop(8'h5a), .i_rssi(8'hc3),
    .i_carrier_offset(32'h12345678), .i_synth_prog(synth_prog),
    .i_rx_bit(rbit), .i_rx_bit_valid(rval), .o_osc_en(osc),
    .o_ref_en(rf), .o_synth_en(syn), .o_synth_tx(), .o_rx_en(rx),
    .o_tx_en(txe), .o_lposc_en(lpo), .o_pa_on(pa), .o_freq_step(fstep),
    .o_phase(), .o_amp_shape_en(amp), .o_freq_shape(fshp),
    .o_sym_strobe(), .o_rx_aligned());
  radio_link_checker u_radio_link_checker (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .sel_n(lk.sel_n), .req(lk.req), .we(lk.we),
    .addr(lk.addr), .wdata(lk.wdata), .rdata(lk.rdata), .ack(lk.ack),
    .miso(lk.miso));

  always #4 i_clk = ~i_clk;

  // ====
  // Access tasks
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    while (ready !== 1'b1) @(negedge i_clk);
    cmd_valid = 1'b1;
    cmd_we = w;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge i_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 100) bad_count++;
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(rsp_data, e);
  endtask : rd

  task automatic pw(input logic [7:0] c);
    acc(1'b1, 8'h00, c);
    rd(8'h00, c);
  endtask : pw

  // Received bits, MSB first, one strobe every second cycle
  task automatic sb(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rbit = b[i];
      rval = 1'b1;
      @(negedge i_clk);
      rval = 1'b0;
      @(negedge i_clk);
    end
  endtask : sb

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    #40000;
    bad_count++;
    report_and_stop();
  end

  // ====
  // Scenarios
  initial begin
    {i_clk, i_rst_n, cmd_valid, cmd_we, wake, synth_prog, rbit, rval} = 8'h0;
    {cmd_addr, cmd_wdata} = 16'h0;
    repeat (10) @(negedge i_clk);
    i_rst_n = 1'b1;
    rd(8'h01, 8'h10);
    rd(8'h03, 8'h08);
    rd(8'h04, 8'haa);
    rd(8'h09, 8'h00);
    synth_prog = 1'b1;
    rd(8'h09, 8'h5a);
    rd(8'h0a, 8'hc3);
    rd(8'h0b, 8'h78);
    rd(8'h0e, 8'h12);
    rd(8'h20, 8'h00);
    acc(1'b1, 8'h03, 8'h02);
    rd(8'h03, 8'h04);
    acc(1'b1, 8'h03, 8'h28);
    rd(8'h03, 8'h20);
    acc(1'b1, 8'h03, 8'h08);
    acc(1'b1, 8'h02, 8'h01);
    pw(8'h00);
    chk({4'h0, osc, rf, syn, rx}, 8'h00);
    pw(8'h05);
    chk({5'h0, osc, rf, rx}, 8'h06);
    pw(8'h08);
    chk({6'h0, syn, rx}, 8'h02);
    pw(8'h09);
    chk({6'h0, syn, rx}, 8'h03);
    sb(8'h0f);
    acc(1'b0, 8'h10, 8'h00);
    chk(rsp_data & 8'h04, 8'h00);
    sb(8'haa);
    acc(1'b0, 8'h10, 8'h00);
    chk(rsp_data & 8'h04, 8'h04);
    sb(8'h3c);
    rd(8'h0f, 8'h3c);
    pw(8'h0b);
    chk({7'h0, lpo}, 8'h01);
    acc(1'b1, 8'h00, 8'h03);
    rd(8'h00, 8'h0b);
    pw(8'h06);
    chk({7'h0, rf}, 8'h01);
    acc(1'b1, 8'h0f, 8'h3c);
    acc(1'b1, 8'h0f, 8'h55);
    acc(1'b1, 8'h00, 8'h05);
    acc(1'b0, 8'h10, 8'h00);
    chk(rsp_data & 8'h11, 8'h10);
    rd(8'h0f, 8'h3c);
    rd(8'h0f, 8'h55);
    acc(1'b0, 8'h10, 8'h00);
    chk(rsp_data & 8'h11, 8'h01);
    rd(8'h0f, 8'h00);
    acc(1'b1, 8'h01, 8'h00);
    pw(8'h06);
    acc(1'b1, 8'h0f, 8'ha5);
    pw(8'h0c);
    acc(1'b1, 8'h00, 8'h0d);
    chk(n > 10, 1'b1);
    rd(8'h00, 8'h0d);
    repeat (20) @(negedge i_clk);
    chk({6'h0, txe, pa}, 8'h03);
    repeat (16) @(negedge i_clk);
    chk({7'h0, pa}, 8'h00);
    acc(1'b1, 8'h01, 8'h07);
    repeat (8) @(negedge i_clk);
    chk({5'h0, fstep}, 8'h03);
    chk({5'h0, amp, fshp}, 8'h04);
    acc(1'b1, 8'h00, 8'h01);
    wake = 1'b1;
    n = 0;
    while (awake !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    wake = 1'b0;
    chk(n < 100, 1'b1);
    rd(8'h01, 8'h10);
    rd(8'h00, 8'h00);
    report_and_stop();
  end
endmodule : test_radio_power_modem_control
